// File: shared/scs_consts.svh
/*
  Offsets, field positions, reset values and timing counts of the system
  clock select switch. Assumes a 25 MHz block clock.
*/
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH

`define SCS_CTRL_OFS 8'h00
`define SCS_STAT_OFS 8'h04
`define SCS_CFG_OFS 8'h08

`define SCS_MULT_EN_BIT 7
`define SCS_FREQ_MSB 6
`define SCS_FREQ_LSB 3
`define SCS_SRC_MSB 1
`define SCS_SRC_LSB 0

`define SCS_ST_MULT_RDY 6
`define SCS_ST_STARTUP 5
`define SCS_ST_HF_RDY 4
`define SCS_ST_HF_LOCK 3
`define SCS_ST_MF_RDY 2
`define SCS_ST_LF_RDY 1
`define SCS_ST_HF_STABLE 0

`define SCS_CFG_MULT_BIT 2

`define SCS_FREQ_RESET 4'h7
`define SCS_FREQ_MULT 4'he
`define SCS_SRC_RESET 2'h0

`define SCS_CLK_NS 40
`define SCS_INT_START_NS 2000
`define SCS_MULT_START_NS 2000000
`define SCS_INT_START_CYC ((`SCS_INT_START_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS)
`define SCS_MULT_START_CYC \
  ((`SCS_MULT_START_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS)
`define SCS_WARM_CYC 64

`define SCS_RESP_OKAY 2'h0
`define SCS_RESP_SLVERR 2'h2

`endif

// File: shared/scs_pkg.sv
/*
  Types of the system clock select switch.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package scs_pkg;
  typedef enum logic [2:0] {
    SRC_LF = 3'h0,
    SRC_MF = 3'h1,
    SRC_HF = 3'h2,
    SRC_MULT = 3'h3,
    SRC_T1 = 3'h4,
    SRC_EXT = 3'h5
  } scs_src_type;

  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_START = 2'h1,
    ST_FALL = 2'h2,
    ST_RISE = 2'h3
  } scs_state_type;
endpackage
`default_nettype wire

// File: verilog/scs_clock_switch.sv
/*
  Glitch-free system clock select switch with an AXI4-Lite register port.
  Assumes the oscillator block feeds six candidate clocks, already
  postscaled per freqApplied, all asynchronous to clk.
*/
`include "scs_consts.svh"
`default_nettype none

// Operation
// - Codes 1111 to 1000 select HF frequencies
// - Codes 0111-0100,0010 MF; 0011 HF; 000x LF
// - Reset loads frequency field with 0111
// - No multiplier when source field is 1x
// - Config multiplier enable overrides software bit
// - Software bit 7 switches multiplier otherwise
// - Start, fall old, hold low, rise new
// - Same oscillator switches without start delay
// - Source field picks default, timer, internal
// - Reset clears source select field
// - Hardware switches never alter source field
// - Status shows HF, MF and LF oscillators running
// - Multiplier ready follows completed 32 MHz switch
// - Wait 2 us HF/MF, 2 ms multiplier
// - Warm-up delay after reset into internal
// - Duplicate codes; same source switches faster
// - Bit 2 reads zero; frequency in 6-3
// - Status bit 6 is multiplier ready
// - Startup status 1 on configured clock
module scs_clock_switch import scs_pkg::*; #(
  parameter int MULT_START_CYC = `SCS_MULT_START_CYC,
  parameter int WARM_CYC = `SCS_WARM_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [5:0] clkIn,
  output logic sysClk,
  output logic hfEnable,
  output logic mfEnable,
  output logic lfEnable,
  output logic multEnable,
  output logic [3:0] freqApplied,
  output logic switchBusy
);
  localparam int CW = 17;
  localparam logic [CW-1:0] INT_CYC = CW'(`SCS_INT_START_CYC);

  logic swMult;
  logic [3:0] freqSel;
  logic [1:0] srcSel;
  logic [1:0] cfgSrc;
  logic cfgMult;
  logic [5:0] clkMeta, clkSync, clkPrev;
  scs_state_type state;
  scs_src_type active, pendSrc, tgtSrc;
  logic [3:0] pendFreq;
  logic [CW-1:0] cnt;
  logic [5:0] oscRun;
  logic multReady;
  logic startupStatus;
  logic awPend, wPend;
  logic [7:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic [7:0] statusByte;
  logic multWanted, request, oldFall, newRise;

  // frequency decode: HF codes and duplicate 0011
  // frequency decode: MF codes, LF at 000x
  function automatic scs_src_type freqOsc(input logic [3:0] f);
    if (f[3] || f == 4'h3) begin
      freqOsc = SRC_HF;
    end else if (f[2] || f == 4'h2) begin
      freqOsc = SRC_MF;
    end else begin
      freqOsc = SRC_LF;
    end
  endfunction

  // multiplier gating: all conditions at once
  // multiplier gating: only with source field 00
  assign multWanted = srcSel == 2'h0 && cfgSrc == 2'h0 &&
    freqSel == `SCS_FREQ_MULT && (cfgMult || swMult);

  always_comb begin
    if (srcSel[1]) begin
      tgtSrc = freqOsc(freqSel);
    end else if (srcSel == 2'h1) begin
      tgtSrc = SRC_T1;
    end else if (cfgSrc != 2'h0) begin
      tgtSrc = SRC_EXT;
    end else if (multWanted) begin
      tgtSrc = SRC_MULT;
    end else begin
      tgtSrc = freqOsc(freqSel);
    end
  end

  // change detect: only a new source or frequency
  assign request = tgtSrc != active || freqSel != freqApplied;

  // Candidate clocks are asynchronous; edges come from the second stage
  always_ff @(posedge clk) begin
    clkMeta <= clkIn;
    clkSync <= clkMeta;
    clkPrev <= clkSync;
  end
  assign oldFall = clkPrev[active] && !clkSync[active];
  assign newRise = !clkPrev[pendSrc] && clkSync[pendSrc];

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_START;
      active <= SRC_MF;
      pendSrc <= SRC_MF;
      pendFreq <= `SCS_FREQ_RESET;
      freqApplied <= `SCS_FREQ_RESET;
      cnt <= CW'(WARM_CYC);
      sysClk <= 1'b0;
    end else begin
      case (state)
        ST_RUN: begin
          sysClk <= clkSync[active];
          if (request) begin
            pendSrc <= tgtSrc;
            pendFreq <= freqSel;
            // no start delay: oscillator already runs
            // faster path on the shared oscillator
            if (tgtSrc == SRC_MULT && !oscRun[SRC_MULT]) begin
              state <= ST_START;
              cnt <= CW'(MULT_START_CYC);
            // start-up wait for a stopped oscillator
            end else if ((tgtSrc == SRC_HF || tgtSrc == SRC_MF) &&
                         !oscRun[tgtSrc]) begin
              state <= ST_START;
              cnt <= INT_CYC;
            end else begin
              state <= ST_FALL;
            end
          end
        end
        ST_START: begin
          // old clock keeps running while the new one starts
          sysClk <= clkSync[active];
          if (cnt != '0) begin
            cnt <= cnt - CW'(1);
          end else begin
            state <= ST_FALL;
          end
        end
        ST_FALL: begin
          // no cut pulse: follow old clock until it falls
          sysClk <= clkSync[active];
          if (!sysClk || oldFall) begin
            sysClk <= 1'b0;
            state <= ST_RISE;
            freqApplied <= pendFreq;
          end
        end
        ST_RISE: begin
          // held low until the new clock rises
          sysClk <= 1'b0;
          if (newRise) begin
            sysClk <= 1'b1;
            active <= pendSrc;
            state <= ST_RUN;
          end
        end
        default: begin
          state <= ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      oscRun <= 6'h00;
      multReady <= 1'b0;
      startupStatus <= 1'b0;
    end else begin
      if (state == ST_START && cnt == '0) begin
        oscRun[pendSrc] <= 1'b1;
      end
      if (state == ST_RISE && newRise) begin
        oscRun[pendSrc] <= 1'b1;
        multReady <= pendSrc == SRC_MULT;
        // shown by status, source field untouched
        startupStatus <= pendSrc == SRC_EXT;
      end
      if (state == ST_RUN && !request) begin
        // Idle oscillators stop to save power once a switch settles
        oscRun <= oscRun & (6'h01 << active);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hfEnable <= 1'b0;
      mfEnable <= 1'b0;
      lfEnable <= 1'b0;
      multEnable <= 1'b0;
      switchBusy <= 1'b1;
    end else begin
      hfEnable <= active == SRC_HF || pendSrc == SRC_HF;
      mfEnable <= active == SRC_MF || pendSrc == SRC_MF;
      lfEnable <= active == SRC_LF || pendSrc == SRC_LF;
      multEnable <= active == SRC_MULT || pendSrc == SRC_MULT;
      switchBusy <= state != ST_RUN;
    end
  end

  always_comb begin
    statusByte = 8'h00;
    statusByte[`SCS_ST_MULT_RDY] = multReady;
    statusByte[`SCS_ST_STARTUP] = startupStatus;
    statusByte[`SCS_ST_HF_RDY] = oscRun[SRC_HF];
    statusByte[`SCS_ST_HF_LOCK] = oscRun[SRC_HF];
    statusByte[`SCS_ST_MF_RDY] = oscRun[SRC_MF];
    statusByte[`SCS_ST_LF_RDY] = oscRun[SRC_LF];
    statusByte[`SCS_ST_HF_STABLE] = oscRun[SRC_HF];
  end

  // AXI4-Lite write: address and data taken in either order
  always_ff @(posedge clk) begin
    if (rst) begin
      awPend <= 1'b0;
      wPend <= 1'b0;
      awAddr <= 8'h00;
      wData <= 32'h0;
      wStrb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SCS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awPend <= 1'b1;
        awAddr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wPend <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (awPend && wPend && !s_axi_bvalid) begin
        awPend <= 1'b0;
        wPend <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr == `SCS_CTRL_OFS ||
          awAddr == `SCS_CFG_OFS || awAddr == `SCS_STAT_OFS) ?
          `SCS_RESP_OKAY : `SCS_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      swMult <= 1'b0;
      freqSel <= `SCS_FREQ_RESET;
      srcSel <= `SCS_SRC_RESET;
      cfgSrc <= 2'h0;
      cfgMult <= 1'b0;
    end else if (awPend && wPend && !s_axi_bvalid && wStrb[0]) begin
      if (awAddr == `SCS_CTRL_OFS) begin
        swMult <= wData[`SCS_MULT_EN_BIT];
        freqSel <= wData[`SCS_FREQ_MSB:`SCS_FREQ_LSB];
        srcSel <= wData[`SCS_SRC_MSB:`SCS_SRC_LSB];
      end else if (awAddr == `SCS_CFG_OFS) begin
        cfgSrc <= wData[1:0];
        cfgMult <= wData[`SCS_CFG_MULT_BIT];
      end
    end
  end

  // AXI4-Lite read, one cycle after the address is taken
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `SCS_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `SCS_RESP_OKAY;
        case (s_axi_araddr)
          `SCS_CTRL_OFS: s_axi_rdata <= {24'h0, swMult, freqSel,
                                         1'b0, srcSel};
          `SCS_STAT_OFS: s_axi_rdata <= {24'h0, statusByte};
          `SCS_CFG_OFS: s_axi_rdata <= {29'h0, cfgMult, cfgSrc};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `SCS_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  sequence fallTaken;
    state == ST_FALL && (!sysClk || oldFall);
  endsequence

  sequence riseTaken;
    state == ST_RISE && newRise;
  endsequence

  reset_fields_a: assert property (@(posedge clk)
    rst |=> freqSel == 4'h7 && srcSel == 2'h0 && !swMult)
    else $error("control fields wrong after reset");
  mult_source_a: assert property (@(posedge clk) disable iff (rst)
    tgtSrc == SRC_MULT |-> srcSel == 2'h0 && freqSel == 4'he)
    else $error("multiplier chosen with wrong fields");
  cfg_override_a: assert property (@(posedge clk) disable iff (rst)
    (cfgMult && cfgSrc == 2'h0 && srcSel == 2'h0 && freqSel == 4'he)
    |-> tgtSrc == SRC_MULT)
    else $error("config multiplier enable ignored");
  switch_order_a: assert property (@(posedge clk) disable iff (rst)
    fallTaken |=> state == ST_RISE && !sysClk)
    else $error("clock not held low after old falling edge");
  same_osc_a: assert property (@(posedge clk) disable iff (rst)
    (state == ST_RUN && request && tgtSrc != SRC_MULT &&
     oscRun[tgtSrc]) |=> state == ST_FALL)
    else $error("start delay on a running oscillator");
  start_wait_a: assert property (@(posedge clk) disable iff (rst)
    (state == ST_START && cnt != '0) |=> state == ST_START)
    else $error("start-up wait cut short");
  run_flag_a: assert property (@(posedge clk) disable iff (rst)
    $rose(oscRun[SRC_HF]) |-> $past(state) != ST_RUN)
    else $error("oscillator shown running without start");
  mult_ready_a: assert property (@(posedge clk) disable iff (rst)
    riseTaken ##1 active == SRC_MULT |-> multReady)
    else $error("multiplier ready missing after switch");
  glitch_free_a: assert property (@(posedge clk) disable iff (rst)
    riseTaken |=> sysClk ##1
      (state != ST_RUN || sysClk == $past(clkSync[active])))
    else $error("system clock glitch after switch");
  startup_bit_a: assert property (@(posedge clk) disable iff (rst)
    (riseTaken and pendSrc == SRC_EXT) |=> startupStatus)
    else $error("startup status not set");
endmodule
`default_nettype wire

// File: bench/tb.sv
/*
  Self-checking bench of the clock select switch.
  Assumes scs_consts.svh on the include path and a 25 MHz block clock.
*/
`include "scs_consts.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0;
  logic rst = 1;
  logic [7:0] awAddr = 0, arAddr = 0, seed = 8'h59, d, clkCnt = 0;
  logic awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
  logic [31:0] wData = 0, rv;
  logic [3:0] wStrb = 4'hf;
  logic [5:0] clkIn = 0;
  logic awReady, wReady, bValid, arReady, rValid, sysClk, busy;
  logic hfEn, mfEn, lfEn, multEn;
  logic [1:0] bResp, rResp, rsp;
  logic [31:0] rdOut;
  logic [3:0] freqApplied;
  int nFail = 0, checked = 0, n, m;

  always #20 clk = ~clk;
  // Candidate clocks at divided rates; LF slowest
  always @(posedge clk) begin
    clkCnt <= clkCnt + 8'h01;
    clkIn <= {clkCnt[0], clkCnt[3], clkCnt[1], clkCnt[2], clkCnt[3],
              clkCnt[4]};
  end

  scs_clock_switch #(.MULT_START_CYC(20), .WARM_CYC(4)) scs_clock_switch_inst (
    .clk(clk), .rst(rst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rdOut), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady), .clkIn(clkIn),
    .sysClk(sysClk), .hfEnable(hfEn), .mfEnable(mfEn), .lfEnable(lfEn),
    .multEnable(multEn), .freqApplied(freqApplied), .switchBusy(busy));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Expected running oscillator {hf, mf, lf} for a frequency code
  function automatic logic [2:0] oscOf(input logic [3:0] c);
    if (c >= 4'h8 || c == 4'h3) return 3'b100;
    if (c >= 4'h4 || c == 4'h2) return 3'b010;
    return 3'b001;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      nFail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", checked, nFail);
    if (nFail == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Ready is registered, so its level at the falling edge is what the
  // next rising edge samples; release happens just after that edge
  task automatic axw(input logic [7:0] a, input logic [31:0] dt,
                     output logic [1:0] r);
    logic ta, tw, tk;
    ta = 0;
    tw = 0;
    tk = 0;
    awAddr <= a;
    wData <= dt;
    awValid <= 1;
    wValid <= 1;
    bReady <= 1;
    while (!tk) begin
      @(negedge clk);
      ta = awValid && awReady;
      tw = wValid && wReady;
      tk = bValid && bReady;
      r = bResp;
      @(posedge clk);
      if (ta) awValid <= 0;
      if (tw) wValid <= 0;
    end
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] dt,
                     output logic [1:0] r);
    logic ta, tk;
    ta = 0;
    tk = 0;
    arAddr <= a;
    arValid <= 1;
    rReady <= 1;
    while (!tk) begin
      @(negedge clk);
      ta = arValid && arReady;
      tk = rValid && rReady;
      dt = rdOut;
      r = rResp;
      @(posedge clk);
      if (ta) arValid <= 0;
    end
  endtask

  // Counts busy cycles of a switch, bounded
  task automatic settle(output int cnt);
    cnt = 0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    while (busy !== 1'b0 && cnt < 3000) begin
      cnt++;
      @(negedge clk);
    end
    chk(busy, 1'b0);
    @(posedge clk);
  endtask

  task automatic stat(input logic [31:0] mask, input logic [31:0] exp);
    axr(`SCS_STAT_OFS, rv, rsp);
    chk(rv & mask, exp);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    axr(`SCS_CTRL_OFS, rv, rsp);
    chk(rv, 32'h38);
    settle(n);
    chk(freqApplied, 4'h7);
    stat(32'h66, 32'h04);
    // Every code in order, then random codes; source kept at 1x
    for (int i = 0; i < 28; i++) begin
      seed = lfsr(seed);
      d = (i < 16) ? {seed[7], i[3:0], seed[2], 1'b1, seed[0]} : seed | 8'h02;
      axw(`SCS_CTRL_OFS, {24'h0, d}, rsp);
      chk(rsp, `SCS_RESP_OKAY);
      settle(n);
      axr(`SCS_CTRL_OFS, rv, rsp);
      chk(rv, {24'h0, d & 8'hfb});
      chk({hfEn, mfEn, lfEn, multEn}, {oscOf(d[6:3]), 1'b0});
      m = oscOf(d[6:3]);
      stat(32'h76, {25'h0, 2'b00, m[2], 1'b0, m[1:0], 1'b0});
      if (d[6:4] != 3'h0) chk(freqApplied, d[6:3]);
    end
    // Same oscillator against a stopped one
    axw(`SCS_CTRL_OFS, 32'h3a, rsp);
    settle(n);
    axw(`SCS_CTRL_OFS, 32'h32, rsp);
    settle(n);
    axw(`SCS_CTRL_OFS, 32'h7a, rsp);
    settle(m);
    chk(n < 50 && m > 50, 1);
    // Multiplier through the software and config bits, then configured and timer sources
    axw(`SCS_CTRL_OFS, 32'hf0, rsp);
    settle(n);
    chk(n > 20 && multEn === 1'b1, 1);
    stat(32'h60, 32'h40);
    axw(`SCS_CTRL_OFS, 32'h70, rsp);
    settle(n);
    stat(32'h40, 32'h00);
    axw(`SCS_CFG_OFS, 32'h04, rsp);
    settle(n);
    stat(32'h40, 32'h40);
    axw(`SCS_CFG_OFS, 32'h01, rsp);
    settle(n);
    stat(32'h60, 32'h20);
    axr(`SCS_CTRL_OFS, rv, rsp);
    chk(rv, 32'h70);
    axw(`SCS_CFG_OFS, 32'h00, rsp);
    settle(n);
    axw(`SCS_CTRL_OFS, 32'h71, rsp);
    settle(n);
    stat(32'h76, 32'h00);
    chk({hfEn, mfEn, lfEn, multEn}, 4'h0);
    // Write without byte strobe stores nothing
    wStrb <= 4'h0;
    axw(`SCS_CTRL_OFS, 32'h3a, rsp);
    wStrb <= 4'hf;
    axr(`SCS_CTRL_OFS, rv, rsp);
    chk(rv, 32'h71);
    // Unmapped place
    axw(8'h0c, 32'hff, rsp);
    chk(rsp, `SCS_RESP_SLVERR);
    axr(8'h0c, rv, rsp);
    chk({rv[29:0], rsp}, {30'h0, `SCS_RESP_SLVERR});
    // Reset in mid-run
    axw(`SCS_CTRL_OFS, 32'hfa, rsp);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    axr(`SCS_CTRL_OFS, rv, rsp);
    chk(rv, 32'h38);
    settle(n);
    // System clock runs from the new source once settled
    m = 0;
    d = {7'h0, sysClk};
    repeat (64) begin
      @(negedge clk);
      if (sysClk !== d[0]) m++;
      d = {7'h0, sysClk};
    end
    chk(m >= 6, 1);
    conclude;
  end

  initial begin
    repeat (30000) @(posedge clk);
    nFail++;
    conclude;
  end
endmodule
`default_nettype wire
